// File: core/utf_pkg.sv
// package: register map, field layout, reset values and timing for unknown traffic control
package utf_pkg;
    localparam logic [7:0] UTF_OFS_MCAST    = 8'h84;
    localparam logic [7:0] UTF_OFS_VLAN     = 8'h85;
    localparam logic [7:0] UTF_OFS_SELF     = 8'h86;
    localparam logic [7:0] UTF_OFS_RATE     = 8'h87;
    localparam int         UTF_EN_BIT       = 5;
    localparam int         UTF_SELF_BIT     = 6;
    localparam int         UTF_RATE_LSB     = 4;
    localparam logic [4:0] UTF_MAP_RST      = 5'h00;
    localparam logic [1:0] UTF_RATE_RST     = 2'h1;
    localparam logic [7:0] UTF_MCAST_RO_RST = 8'h40;
    localparam logic [4:0] UTF_PORTS_ALL    = 5'h1F;
    localparam int         UTF_CLK_MHZ      = 100;
    localparam int         UTF_MS_16        = 16;
    localparam int         UTF_MS_64        = 64;
    localparam int         UTF_MS_256       = 256;
    localparam int         UTF_CYC_PER_MS   = UTF_CLK_MHZ * 1000;

    typedef struct packed {
        logic       en;
        logic [4:0] map;
    } utf_class_t;

    typedef struct packed {
        utf_class_t mcast;
        utf_class_t vlan;
        utf_class_t ipmc;
        logic       self_filter;
        logic [1:0] rate_sel;
    } utf_cfg_t;

    typedef struct packed {
        logic [4:0] mcast;
        logic [4:0] vlan;
        logic [4:0] ipmc;
    } utf_fwd_t;
endpackage : utf_pkg

// File: core/utf_period_tick.sv
// measurement period divider for ingress rate limiting
`timescale 1ns/1ps
module utf_period_tick #(
    parameter int unsigned CYC_PER_MS = utf_pkg::UTF_CYC_PER_MS
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [1:0] rate_sel,
    output logic            tick
);
    import utf_pkg::*;
    localparam logic [31:0] LIM16  = 32'(UTF_MS_16 * CYC_PER_MS);
    localparam logic [31:0] LIM64  = 32'(UTF_MS_64 * CYC_PER_MS);
    localparam logic [31:0] LIM256 = 32'(UTF_MS_256 * CYC_PER_MS);

    logic [31:0] cnt_q;
    wire  [31:0] limit = (rate_sel == 2'h0) ? LIM16 :
                         (rate_sel == 2'h1) ? LIM64 : LIM256;
    wire         wrap  = (cnt_q >= limit - 32'h1);

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= 32'h0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1;
            tick  <= wrap;
        end
    end
endmodule : utf_period_tick

// File: core/utf_ctrl.sv
// register bank for unknown traffic forwarding, self filtering and rate period
`timescale 1ns/1ps
// Notes on behaviour
// - the unknown multicast port map resets to zero and zero filters while all ones floods.
// - a reset-zero enable bit turns on unknown non-ip multicast forwarding by its map.
// - bit 5 of the unknown vlan register enables unknown vlan forwarding and resets to zero.
// - bits 4 to 0 of the unknown vlan register are its port map, zero filters, ones flood.
// - bit 6 of the self register set makes the device drop frames for its own mac address.
// - self filtering is applied at egress against the switch's own mac address.
// - bit 5 of the self register enables unknown ip multicast forwarding, reset zero.
// - the unknown ip multicast port map resets to zero, zero filters, all ones floods.
// - bits 5 to 4 of the rate register pick 16, 64 (reset) or 256 ms as rate period.
module utf_ctrl #(
    parameter int unsigned CYC_PER_MS = utf_pkg::UTF_CYC_PER_MS
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [7:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    input  wire logic [4:0]       default_ports,
    input  wire logic             egress_valid,
    input  wire logic [47:0]      egress_da,
    input  wire logic [47:0]      own_mac,
    output logic                  egress_drop,
    output utf_pkg::utf_fwd_t     fwd_ports,
    output utf_pkg::utf_cfg_t     cfg,
    output logic                  period_tick
);
    import utf_pkg::*;

    // configuration registers, reserved bits are not stored
    logic [5:0]  mcast_q;
    logic [5:0]  vlan_q;
    logic [6:0]  self_q;
    logic [1:0]  rate_q;
    // bus handshake state
    logic        ack_q;
    logic        wait_q;
    logic [31:0] rdata_q;
    // registered outputs towards the forwarding engine
    utf_fwd_t    fwd_q;
    utf_cfg_t    cfg_q;
    logic        drop_q;
    logic        tick_q;
    logic        tick_w;
    utf_fwd_t    fwd_d;
    utf_cfg_t    cfg_d;

    function automatic logic [4:0] pick(input logic       en,
                                        input logic [4:0] map,
                                        input logic [4:0] dflt);
        pick = en ? map : dflt;
    endfunction : pick

    // one wait cycle per access keeps readdata registered
    wire       busy    = avs_read | avs_write;
    wire       req     = busy & ~ack_q;
    // only byte lane 0 carries a register, other lanes are ignored
    wire       lane0   = avs_byteenable[0];
    wire       wr_en   = avs_write & ack_q & lane0;
    wire [7:0] wd      = avs_writedata[7:0];
    wire       hit_mc  = (avs_address == UTF_OFS_MCAST);
    wire       hit_vl  = (avs_address == UTF_OFS_VLAN);
    wire       hit_sf  = (avs_address == UTF_OFS_SELF);
    wire       hit_rt  = (avs_address == UTF_OFS_RATE);
    wire       wr_mc   = wr_en & hit_mc;
    wire       wr_vl   = wr_en & hit_vl;
    wire       wr_sf   = wr_en & hit_sf;
    wire       wr_rt   = wr_en & hit_rt;

    // a write lands on the edge that ends the wait-low cycle
    wire [5:0] mcast_d = wr_mc ? wd[5:0] : mcast_q;
    wire [5:0] vlan_d  = wr_vl ? wd[5:0] : vlan_q;
    wire [6:0] self_d  = wr_sf ? wd[6:0] : self_q;
    wire [1:0] rate_d  = wr_rt ? wd[UTF_RATE_LSB +: 2] : rate_q;

    // field views of the stored registers
    wire       mc_en   = mcast_q[UTF_EN_BIT];
    wire [4:0] mc_map  = mcast_q[4:0];
    wire       vl_en   = vlan_q[UTF_EN_BIT];
    wire [4:0] vl_map  = vlan_q[4:0];
    wire       ip_en   = self_q[UTF_EN_BIT];
    wire [4:0] ip_map  = self_q[4:0];
    wire       sf_en   = self_q[UTF_SELF_BIT];

    // reserved bits read as their fixed values, unmapped addresses read zero
    wire [7:0] rd_mc   = UTF_MCAST_RO_RST | {2'h0, mcast_q};
    wire [7:0] rd_vl   = {2'h0, vlan_q};
    wire [7:0] rd_sf   = {1'b0, self_q};
    wire [7:0] rd_rt   = {2'h0, rate_q, 4'h0};
    wire [7:0] rd_mux  = hit_mc ? rd_mc :
                         hit_vl ? rd_vl :
                         hit_sf ? rd_sf :
                         hit_rt ? rd_rt : 8'h00;

    // handshake next values
    wire        ack_d   = req;
    wire        wait_d  = ~req;
    wire [31:0] rdata_d = req ? {24'h0, rd_mux} : rdata_q;

    // outputs trail the registers by one cycle
    wire       da_own  = egress_valid & (egress_da == own_mac);
    wire       drop_d  = sf_en & da_own;
    assign fwd_d = '{mcast: pick(mc_en, mc_map, default_ports),
                     vlan:  pick(vl_en, vl_map, default_ports),
                     ipmc:  pick(ip_en, ip_map, default_ports)};
    assign cfg_d = '{mcast:       '{en: mc_en, map: mc_map},
                     vlan:        '{en: vl_en, map: vl_map},
                     ipmc:        '{en: ip_en, map: ip_map},
                     self_filter: sf_en,
                     rate_sel:    rate_q};

    always_ff @(posedge mclk) begin
        if (rst) begin
            mcast_q <= {1'b0, UTF_MAP_RST};
        end else begin
            mcast_q <= mcast_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            vlan_q <= {1'b0, UTF_MAP_RST};
        end else begin
            vlan_q <= vlan_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            self_q <= {2'b00, UTF_MAP_RST};
        end else begin
            self_q <= self_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rate_q <= UTF_RATE_RST;
        end else begin
            rate_q <= rate_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // waitrequest idles high and drops for the cycle the access completes
    always_ff @(posedge mclk) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= wait_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            fwd_q <= '0;
        end else begin
            fwd_q <= fwd_d;
        end
    end

    // rate field shows one cycle late after reset, hence the zero here
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            drop_q <= 1'b0;
        end else begin
            drop_q <= drop_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_w;
        end
    end

    // every output is a flop
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign fwd_ports       = fwd_q;
    assign cfg             = cfg_q;
    assign egress_drop     = drop_q;
    assign period_tick     = tick_q;

    utf_period_tick #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_tick (
        .mclk     (mclk),
        .rst      (rst),
        .rate_sel (rate_q),
        .tick     (tick_w)
    );
endmodule : utf_ctrl

// File: bench/utf_ctrl_chk.sv
// checker for the unknown traffic control register bank
`timescale 1ns/1ps
module utf_ctrl_chk
    import utf_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic              avs_waitrequest,
    input wire logic [4:0]        default_ports,
    input wire logic              egress_valid,
    input wire logic [47:0]       egress_da,
    input wire logic [47:0]       own_mac,
    input wire logic              egress_drop,
    input wire utf_pkg::utf_fwd_t fwd_ports,
    input wire utf_pkg::utf_cfg_t cfg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // three quiet cycles, so map register and cfg copy surely agree
    sequence steady; (!rst && $stable(cfg) && $stable(default_ports)) [*3]; endsequence
    wire own_hit = egress_valid && (egress_da == own_mac);
    AST_WAIT_ANS: assert property ($rose(avs_read | avs_write) |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_MCAST: assert property (steady |-> fwd_ports.mcast ==
        (cfg.mcast.en ? cfg.mcast.map : default_ports)) else $error("mcast ports wrong");
    AST_VLAN: assert property (steady |-> fwd_ports.vlan ==
        (cfg.vlan.en ? cfg.vlan.map : default_ports)) else $error("vlan ports wrong");
    AST_IPMC: assert property (steady |-> fwd_ports.ipmc ==
        (cfg.ipmc.en ? cfg.ipmc.map : default_ports)) else $error("ipmc ports wrong");
    AST_DROP_SRC: assert property (egress_drop |-> $past(own_hit))
        else $error("drop without own address");
    AST_DROP_OFF: assert property (!cfg.self_filter && !$past(cfg.self_filter)
        |-> !egress_drop) else $error("drop while filter off");
    AST_DROP_ON: assert property (cfg.self_filter && $past(cfg.self_filter)
        && $past(own_hit) |-> egress_drop) else $error("own address not dropped");
endmodule : utf_ctrl_chk

// File: bench/tb_top.sv
// self-checking bench for the unknown traffic control register bank
`timescale 1ns/1ps
module tb_top;
    import utf_pkg::*;
    logic mclk, rst, avs_read, avs_write, egress_valid, egress_drop, avs_waitrequest, period_tick;
    logic [7:0]  avs_address, r;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [4:0]  default_ports;
    logic [47:0] egress_da, own_mac;
    utf_fwd_t    fwd_ports;
    utf_cfg_t    cfg;
    int          mismatches = 0, n_compared = 0, cyc = 0, n;
    // address, write data, expected read back; 0x88 is unmapped
    logic [23:0] rows[6] = '{24'h84FF7F, 24'h852F2F, 24'h866767, 24'h87FF30, 24'h870000, 24'h88FF00};
    localparam int CPM = 10;
    // expected tick spacing in cycles for rate codes 0 to 3
    int          gap_exp[4] = '{UTF_MS_16 * CPM, UTF_MS_64 * CPM,
                                UTF_MS_256 * CPM, UTF_MS_256 * CPM};
    utf_ctrl #(
        .CYC_PER_MS (CPM)
    ) dut_u (
        .mclk            (mclk),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .default_ports   (default_ports),
        .egress_valid    (egress_valid),
        .egress_da       (egress_da),
        .own_mac         (own_mac),
        .egress_drop     (egress_drop),
        .fwd_ports       (fwd_ports),
        .cfg             (cfg),
        .period_tick     (period_tick)
    );
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge mclk);
        avs_address    <= a;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= be;
        avs_read       <= !w;
        avs_write      <= w;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic tick_gap();
        n = 0;
        do begin @(posedge mclk); n++; end while (period_tick !== 1'b1 && n < 3000);
    endtask : tick_gap
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // whole run stays below about 25000 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        rst = 1'b1;
        {avs_read, avs_write, egress_valid, avs_address, avs_writedata, avs_byteenable} = '0;
        default_ports = 5'h15;
        own_mac = 48'h02A0B0C0D0E0;
        egress_da = 48'h020000000001;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 8'h84 + i[7:0], 8'h00, 4'h1);
            chk("reset value", i == 0 ? 8'h40 : i == 3 ? 8'h10 : 8'h00, r);
        end
        $display("test reset done");
        foreach (rows[i]) begin
            bus(1'b1, rows[i][23:16], rows[i][15:8], 4'h1);
            bus(1'b0, rows[i][23:16], 8'h00, 4'h1);
            chk("read back", rows[i][7:0], r);
        end
        repeat (2) @(posedge mclk);
        chk("mcast ports", 8'h1F, {3'h0, fwd_ports.mcast});
        chk("ipmc ports", 8'h07, {3'h0, fwd_ports.ipmc});
        chk("vlan ports", 8'h0F, {3'h0, fwd_ports.vlan});
        chk("vlan cfg", 8'h2F, {2'h0, cfg.vlan});
        $display("test rows done");
        bus(1'b1, 8'h85, 8'h0F, 4'h1);
        bus(1'b1, 8'h85, 8'h3F, 4'h0);
        repeat (2) @(posedge mclk);
        chk("vlan default", 8'h15, {3'h0, fwd_ports.vlan});
        bus(1'b0, 8'h85, 8'h00, 4'h1);
        chk("lane off write", 8'h0F, r);
        $display("test disabled class done");
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, 8'h86, k ? 8'h40 : 8'h00, 4'h1);
            @(posedge mclk);
            egress_valid <= 1'b1;
            egress_da    <= own_mac;
            @(posedge mclk);
            egress_valid <= 1'b0;
            #1 chk("self drop", k[7:0], {7'h00, egress_drop});
        end
        $display("test self filter done");
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1 chk("reset ports", 8'h00, {3'h0, fwd_ports.mcast});
        bus(1'b0, UTF_OFS_SELF, 8'h00, 4'h1);
        chk("reset self", 8'h00, r);
        bus(1'b0, UTF_OFS_MCAST, 8'h00, 4'h1);
        chk("reset mcast", 8'h40, r);
        $display("test mid reset done");
        // first gap after a rate change may be partial, so the third is judged
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, UTF_OFS_RATE, {2'h0, k[1:0], 4'h0}, 4'h1);
            repeat (2) @(posedge mclk);
            chk("rate sel", {6'h00, k[1:0]}, {6'h00, cfg.rate_sel});
            repeat (3) tick_gap();
            chk("tick gap lo", gap_exp[k][7:0], n[7:0]);
            chk("tick gap hi", gap_exp[k][15:8], n[15:8]);
        end
        $display("test period done");
        final_report();
    end
endmodule : tb_top
bind utf_ctrl utf_ctrl_chk chk_u (
    .mclk            (mclk),
    .rst             (rst),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_waitrequest (avs_waitrequest),
    .default_ports   (default_ports),
    .egress_valid    (egress_valid),
    .egress_da       (egress_da),
    .own_mac         (own_mac),
    .egress_drop     (egress_drop),
    .fwd_ports       (fwd_ports),
    .cfg             (cfg)
);
